// *** pkg/sda_pkg.sv ***
// Constants, register map and types of the sigma-delta averager
package sda_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int CONV_NS = 6400;
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 12;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_CTRL = 16'hF060;
  localparam logic [15:0] IDX_SSR = 16'hF061;
  localparam logic [15:0] IDX_RESULT = 16'hF062;
  localparam logic [15:0] IDX_MEAS = 16'hF070;
  localparam logic [15:0] IDX_AVG = 16'hF080;
  localparam logic [15:0] IDX_IEN = 16'hFFF4;
  localparam logic [15:0] IDX_IRR = 16'hFFF7;
  localparam logic [15:0] IDX_STBY = 16'hFFFA;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE = 7;
  localparam int OVS_LSB = 4;
  localparam int REF_LSB = 2;
  localparam int GAIN_LSB = 0;
  localparam int SSR_START = 7;
  localparam int SSR_BUSY = 6;
  localparam int CHAN_LSB = 4;
  localparam int SSR_BYP = 3;
  localparam int IRQ_BIT = 5;
  localparam int STBY_BIT = 3;
  localparam int MEAS_GO = 0;
  localparam int MEAS_DONE = 1;
  localparam int SLOT_LSB = 4;
  localparam int SLOT_W = 3;
  // ----------------------------------------------------------------
  // Reset values and averaging figures
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [7:0] SSR_RST = 8'h98;
  localparam logic [7:0] IEN_RST = 8'h20;
  localparam logic [7:0] STBY_RST = 8'h08;
  localparam logic [6:0] ROUNDS = 7'h41;
  localparam int IN_SHIFT = 2;
  localparam int AVG_SHIFT = 6;
  localparam int RES_W = 14;
  localparam int ACC_W = 32;
  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_START = 3'b001,
    MS_WAIT = 3'b010,
    MS_ACC = 3'b011,
    MS_STORE = 3'b100
  } sda_meas_e;
endpackage

// *** pkg/sda_mem_if.sv ***
// Write and read ports between the averager and its result memory
`timescale 1ns/1ps
interface sda_mem_if #(parameter int AW = 3, parameter int DW = 16) ();
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** src/sda_avg_mem.sv ***
// Small store for finished averages, registered read data
`timescale 1ns/1ps
module sda_avg_mem
  import sda_pkg::*;
#(
  parameter int DEPTH = 8
)
(
  input wire logic sys_clk,
  sda_mem_if.mem port
);
  logic [15:0] mem_q [DEPTH];

  // Write port; contents are not reset, software reads only stored slots
  always_ff @(posedge sys_clk)
  begin
    if (port.we)
    begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  // Read data comes one cycle after the address
  always_ff @(posedge sys_clk)
  begin
    port.rdata <= mem_q[port.raddr];
  end
endmodule

// *** src/sda_top.sv ***
// Sigma-delta converter control, result register and 64-round averager
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module sda_top
  import sda_pkg::*;
#(
  parameter int DEPTH = 8
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [RES_W-1:0] sample_in,
  output logic modulator_run,
  output logic [2:0] osr_sel,
  output logic [1:0] gain_sel,
  output logic amp_bypass,
  output logic ain_one_en,
  output logic ain_two_en,
  output logic ref_pin_oe_n,
  output logic ref_ext_sel,
  output logic ref_int_sel,
  output logic irq,
  output logic wake_req
);
  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_q, rst_n;
  logic [RES_W-1:0] smp_meta_q, smp_q;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Analog result arrives from another timing world
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      smp_meta_q <= '0;
      smp_q <= '0;
    end
    else
    begin
      smp_meta_q <= sample_in;
      smp_q <= smp_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q, ssr_q, ien_q, irr_q, stby_q, meas_q;
  logic [15:0] result_q;
  logic [ACC_W-1:0] acc_q;
  logic [6:0] round_q;
  logic [CNT_W-1:0] cnt_q;
  logic conv_busy_q, conv_done_q, pready_q, pslverr_q, irq_q, wake_q;
  logic [31:0] prdata_q;
  sda_meas_e ms_q;
  sda_mem_if #(.AW(SLOT_W), .DW(16)) mem_bus ();

  logic [15:0] idx;
  logic acc_ph, wr_en, stby_on, cont_mode, start_req, conv_start, map_hit;
  assign idx = paddr[17:2];
  assign acc_ph = psel && penable;
  assign wr_en = acc_ph && pwrite && pready_q;
  assign stby_on = stby_q[STBY_BIT];
  assign cont_mode = ctrl_q[CTRL_MODE];
  assign map_hit = (paddr[1:0] == 2'h0) &&
                   (idx == IDX_CTRL || idx == IDX_SSR || idx == IDX_RESULT ||
                    idx == IDX_MEAS || idx == IDX_IEN || idx == IDX_IRR ||
                    idx == IDX_STBY || idx[15:SLOT_W] == IDX_AVG[15:SLOT_W]);
  assign start_req = wr_en && idx == IDX_SSR && pwdata[SSR_START] && !cont_mode;

  // One wait state on every transfer lets the memory read settle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= acc_ph && !pready_q;
      pslverr_q <= acc_ph && !pready_q && !map_hit;
      if (acc_ph && !pready_q && !pwrite)
      begin
        prdata_q <= '0;
        unique case (1'b1)
          idx == IDX_CTRL: prdata_q[7:0] <= ctrl_q;
          idx == IDX_SSR: prdata_q[7:0] <= {ssr_q[7], conv_busy_q, ssr_q[5:0]};
          idx == IDX_RESULT: prdata_q[15:0] <= result_q;
          idx == IDX_MEAS: prdata_q[7:0] <= meas_q;
          idx == IDX_IEN: prdata_q[7:0] <= ien_q;
          idx == IDX_IRR: prdata_q[7:0] <= irr_q;
          idx == IDX_STBY: prdata_q[7:0] <= stby_q;
          idx[15:SLOT_W] == IDX_AVG[15:SLOT_W]: prdata_q[15:0] <= mem_bus.rdata;
          default: prdata_q <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RST;
      ssr_q <= SSR_RST;
      ien_q <= IEN_RST;
      stby_q <= STBY_RST;
    end
    else if (wr_en)
    begin
      if (idx == IDX_CTRL)
      begin
        ctrl_q[7] <= pwdata[CTRL_MODE];
        ctrl_q[3:0] <= pwdata[3:0];
        // Prohibited oversample codes are dropped, keeping the old rate
        if (pwdata[OVS_LSB+2:OVS_LSB+1] != 2'b11)
        begin
          ctrl_q[6:4] <= pwdata[OVS_LSB+2:OVS_LSB];
        end
      end
      if (idx == IDX_SSR)
      begin
        ssr_q[7] <= pwdata[SSR_START];
        ssr_q[5:3] <= pwdata[5:3];
      end
      if (idx == IDX_IEN)
      begin
        ien_q[IRQ_BIT] <= pwdata[IRQ_BIT];
      end
      if (idx == IDX_STBY)
      begin
        stby_q[STBY_BIT] <= pwdata[STBY_BIT];
      end
    end
  end

  // Interrupt flag: completion wins over a clearing write in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irr_q <= '0;
    end
    else if (conv_done_q)
    begin
      irr_q[IRQ_BIT] <= 1'b1;
    end
    else if (wr_en && idx == IDX_IRR && !pwdata[IRQ_BIT])
    begin
      irr_q[IRQ_BIT] <= 1'b0;
    end
  end

  // Interrupt line and wake request toward the processor
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      irq_q <= irr_q[IRQ_BIT] && ien_q[IRQ_BIT];
      wake_q <= conv_done_q && ien_q[IRQ_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Converter sequencing
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] conv_len(input logic [2:0] ovs);
    logic [CNT_W-1:0] base;
    base = CNT_W'(CONV_CYC);
    // Slower oversampling clocks stretch the conversion; 10x runs at full rate
    conv_len = ovs[2] ? base : (base << ovs[1:0]);
  endfunction

  assign conv_start = stby_on && !conv_busy_q &&
                      (cont_mode || start_req || ms_q == MS_START);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_busy_q <= 1'b0;
      conv_done_q <= 1'b0;
      cnt_q <= '0;
      result_q <= '0;
    end
    else
    begin
      conv_done_q <= 1'b0;
      if (!stby_on)
      begin
        conv_busy_q <= 1'b0;
      end
      else if (conv_start)
      begin
        conv_busy_q <= 1'b1;
        cnt_q <= conv_len(ctrl_q[6:4]) - CNT_W'(1);
      end
      else if (conv_busy_q && cnt_q != '0)
      begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
      else if (conv_busy_q)
      begin
        conv_busy_q <= 1'b0;
        conv_done_q <= 1'b1;
        result_q <= {smp_q, 2'b00};
      end
    end
  end

  // ----------------------------------------------------------------
  // Measurement: 65 rounds, first discarded, 64 averaged
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms_q <= MS_IDLE;
      round_q <= '0;
      acc_q <= '0;
      meas_q <= '0;
    end
    else if (!stby_on)
    begin
      ms_q <= MS_IDLE;
    end
    else
    begin
      if (wr_en && idx == IDX_MEAS)
      begin
        meas_q[SLOT_LSB+SLOT_W-1:SLOT_LSB] <= pwdata[SLOT_LSB+SLOT_W-1:SLOT_LSB];
      end
      unique case (ms_q)
        MS_IDLE:
          if (wr_en && idx == IDX_MEAS && pwdata[MEAS_GO])
          begin
            round_q <= '0;
            acc_q <= '0;
            meas_q[MEAS_DONE] <= 1'b0;
            meas_q[MEAS_GO] <= 1'b1;
            ms_q <= MS_START;
          end
        MS_START:
          if (conv_start || conv_busy_q)
          begin
            ms_q <= MS_WAIT;
          end
        MS_WAIT:
          if (conv_done_q)
          begin
            ms_q <= MS_ACC;
          end
        MS_ACC:
        begin
          round_q <= round_q + 7'h01;
          // The first round only settles the modulator
          if (round_q != '0)
          begin
            acc_q <= acc_q + {{(ACC_W-RES_W){1'b0}}, result_q[15:IN_SHIFT]};
          end
          ms_q <= (round_q == ROUNDS - 7'h01) ? MS_STORE : MS_START;
        end
        MS_STORE:
        begin
          meas_q[MEAS_GO] <= 1'b0;
          meas_q[MEAS_DONE] <= 1'b1;
          ms_q <= MS_IDLE;
        end
        default: ms_q <= MS_IDLE;
      endcase
    end
  end

  // Average write: sum shifted by six, narrowed with two zero top bits
  assign mem_bus.we = (ms_q == MS_STORE);
  assign mem_bus.waddr = meas_q[SLOT_LSB+SLOT_W-1:SLOT_LSB];
  assign mem_bus.wdata = {2'b00, acc_q[AVG_SHIFT+RES_W-1:AVG_SHIFT]};
  assign mem_bus.raddr = idx[SLOT_W-1:0];

  sda_avg_mem #(.DEPTH(DEPTH)) u_mem (
    .sys_clk(sys_clk),
    .port(mem_bus.mem)
  );

  // ----------------------------------------------------------------
  // Analog steering, registered so every output leaves a flop
  // ----------------------------------------------------------------
  logic run_q, byp_q, a1_q, a2_q, oe_n_q, rext_q, rint_q;
  logic [2:0] osr_q;
  logic [1:0] gain_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_q <= 1'b0;
      osr_q <= '0;
      gain_q <= '0;
      byp_q <= 1'b1;
      a1_q <= 1'b0;
      a2_q <= 1'b0;
      oe_n_q <= 1'b1;
      rext_q <= 1'b0;
      rint_q <= 1'b0;
    end
    else
    begin
      run_q <= conv_busy_q && stby_on;
      osr_q <= ctrl_q[6:4];
      gain_q <= ctrl_q[GAIN_LSB+1:GAIN_LSB];
      byp_q <= ssr_q[SSR_BYP];
      a1_q <= ssr_q[CHAN_LSB+1:CHAN_LSB] == 2'b01;
      a2_q <= ssr_q[CHAN_LSB+1:CHAN_LSB] == 2'b10;
      oe_n_q <= !ctrl_q[REF_LSB+1];
      rext_q <= ctrl_q[REF_LSB+1:REF_LSB] == 2'b01;
      rint_q <= ctrl_q[REF_LSB+1:REF_LSB] == 2'b11;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign modulator_run = run_q;
  assign osr_sel = osr_q;
  assign gain_sel = gain_q;
  assign amp_bypass = byp_q;
  assign ain_one_en = a1_q;
  assign ain_two_en = a2_q;
  assign ref_pin_oe_n = oe_n_q;
  assign ref_ext_sel = rext_q;
  assign ref_int_sel = rint_q;
  assign irq = irq_q;
  assign wake_req = wake_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_store_rounds: assert property (ms_q == MS_STORE |-> round_q == ROUNDS)
    else $error("average stored after wrong round count");
  a_first_dropped: assert property (
    ms_q == MS_ACC && round_q == '0 |=> acc_q == '0)
    else $error("first round entered the sum");
  a_acc_adds: assert property (
    ms_q == MS_ACC && round_q != '0 |=>
      acc_q == $past(acc_q) + {18'h0, $past(result_q[15:2])})
    else $error("accumulator did not add shifted result");
  a_avg_word: assert property (mem_bus.we |-> mem_bus.wdata[15:14] == 2'b00 &&
    mem_bus.wdata[13:0] == acc_q[19:6])
    else $error("stored average malformed");
  a_result_hold: assert property (conv_busy_q && cnt_q != '0 && stby_on |=>
    $stable(result_q))
    else $error("result changed mid conversion");
  a_cont_restart: assert property (conv_done_q && cont_mode && stby_on |=>
    conv_busy_q)
    else $error("continuous mode did not restart");
  a_start_busy: assert property (start_req && stby_on && !conv_busy_q |=>
    conv_busy_q [*2])
    else $error("start did not begin conversion");
  a_ovs_legal: assert property (ctrl_q[6:5] != 2'b11)
    else $error("prohibited oversample code stored");
  a_irq_gated: assert property (!ien_q[IRQ_BIT] && $past(!ien_q[IRQ_BIT]) |-> !irq_q)
    else $error("interrupt without enable");
  a_flag_set: assert property (conv_done_q |=> irr_q[IRQ_BIT])
    else $error("flag not set on completion");
  a_standby_halt: assert property (!stby_on |=> !conv_busy_q ##1 !modulator_run)
    else $error("converter runs in standby");
  a_reserved_zero: assert property (ssr_q[2:0] == 3'h0)
    else $error("reserved status bits changed");
endmodule

// *** tb/sda_analog_model.sv ***
// Behavioural model of the analog input pins feeding the averager
`timescale 1ns/1ps
module sda_analog_model
  import sda_pkg::*;
#(
  parameter logic [13:0] BASE_ONE = 14'h1000,
  parameter logic [13:0] BASE_TWO = 14'h2000
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic modulator_run,
  input wire logic ain_one_en,
  input wire logic ain_two_en,
  output logic [RES_W-1:0] sample_in
);
  logic run_q;
  logic [13:0] cnt_q;

  // Count conversion starts; the value moves only at a start, so it is settled at the end
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_q <= 1'b0;
      cnt_q <= 14'h0000;
    end
    else
    begin
      run_q <= modulator_run;
      if (modulator_run && !run_q)
        cnt_q <= cnt_q + 14'h0001;
    end
  end

  // Each channel has its own level; no channel selected gives a changing pattern
  assign sample_in = ain_two_en ? BASE_TWO + cnt_q :
                     ain_one_en ? BASE_ONE + cnt_q : ~cnt_q;
endmodule

// *** tb/tb_sigma_delta_adc_averager.sv ***
// Self-checking testbench of the sigma-delta averager
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      bad_count++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); \
    end \
  end
module tb_sigma_delta_adc_averager;
  import sda_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, modulator_run, amp_bypass, ain_one_en, ain_two_en;
  logic ref_pin_oe_n, ref_ext_sel, ref_int_sel, irq, wake_req;
  logic [2:0] osr_sel;
  logic [1:0] gain_sel;
  logic [RES_W-1:0] sample_in;
  logic run_q = 1'b0;
  int bad_count = 0;
  int comparisons = 0;
  int rises = 0;
  int wakes = 0;
  int run_len = 0;
  int last_len = 0;

  // --------------------------------------------------------------
  // Clock, design and analog side
  // --------------------------------------------------------------
  always #10 sys_clk = ~sys_clk;

  sda_top #(.DEPTH(8)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
    .modulator_run(modulator_run), .osr_sel(osr_sel), .gain_sel(gain_sel),
    .amp_bypass(amp_bypass), .ain_one_en(ain_one_en), .ain_two_en(ain_two_en),
    .ref_pin_oe_n(ref_pin_oe_n), .ref_ext_sel(ref_ext_sel), .ref_int_sel(ref_int_sel),
    .irq(irq), .wake_req(wake_req));

  sda_analog_model i_model (.sys_clk(sys_clk), .resetn(resetn),
    .modulator_run(modulator_run), .ain_one_en(ain_one_en), .ain_two_en(ain_two_en),
    .sample_in(sample_in));

  // Count conversion starts, wake pulses and the length of each run
  always @(posedge sys_clk)
  begin
    run_q <= modulator_run;
    if (modulator_run === 1'b1 && run_q === 1'b0)
      rises++;
    if (wake_req === 1'b1)
      wakes++;
    if (modulator_run === 1'b1)
      run_len++;
    else if (run_len != 0)
    begin
      last_len = run_len;
      run_len = 0;
    end
  end

  // --------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the watchdog ends a stuck transfer
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h00000000, r, e);
    `CHK(r, x)
  endtask

  task automatic wait_bit(input logic [15:0] idx, input int b, input logic v, input int lim);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, idx, 32'h00000000, r, e);
      n++;
    end
    while (r[b] !== v && n < lim);
    `CHK(r[b], v)
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset_and_map();
    logic [31:0] r;
    logic e;
    rchk(IDX_CTRL, 32'h00000004);
    rchk(IDX_SSR, 32'h00000098);
    rchk(IDX_IEN, 32'h00000020);
    rchk(IDX_IRR, 32'h00000000);
    rchk(IDX_STBY, 32'h00000008);
    `CHK({amp_bypass, ain_one_en, ref_ext_sel, ref_pin_oe_n}, 4'hF)
    apb(1'b0, 16'h0123, 32'h00000000, r, e);
    `CHK(e, 1'b1)
  endtask

  task automatic t_control_fields();
    for (int c = 0; c < 4; c++)
    begin
      // The bandgap counts as running before code 11 picks the internal reference
      wreg(IDX_CTRL, (c << 2) | c);
      repeat (2) @(posedge sys_clk);
      `CHK(gain_sel, 2'(c))
      `CHK({ref_pin_oe_n, ref_ext_sel, ref_int_sel}, {c < 2, c == 1, c == 3})
    end
    wreg(IDX_CTRL, 32'h00000030);
    wreg(IDX_CTRL, 32'h00000060);
    rchk(IDX_CTRL, 32'h00000030);
    `CHK(osr_sel, 3'b011)
    wreg(IDX_CTRL, 32'h00000004);
    wreg(IDX_SSR, 32'h00000027);
    rchk(IDX_SSR, 32'h00000020);
    repeat (2) @(posedge sys_clk);
    `CHK({ain_two_en, ain_one_en, amp_bypass}, 3'b100)
  endtask

  task automatic t_single_and_irq();
    int w;
    w = wakes;
    wreg(IDX_SSR, 32'h000000A0);
    wait_bit(IDX_SSR, SSR_BUSY, 1'b1, 5);
    wait_bit(IDX_SSR, SSR_BUSY, 1'b0, 300);
    rchk(IDX_RESULT, {16'h0000, 14'h2000 + i_model.cnt_q, 2'b00});
    rchk(IDX_IRR, 32'h00000020);
    `CHK({irq, wakes - w}, {1'b1, 32'd1})
    wreg(IDX_IRR, 32'h00000020);
    rchk(IDX_IRR, 32'h00000020);
    wreg(IDX_IRR, 32'h00000000);
    rchk(IDX_IRR, 32'h00000000);
    wreg(IDX_IEN, 32'h00000000);
    // Half-rate oversampling doubles the conversion run
    wreg(IDX_CTRL, 32'h00000014);
    w = wakes;
    wreg(IDX_SSR, 32'h000000A0);
    wait_bit(IDX_SSR, SSR_BUSY, 1'b0, 300);
    repeat (2) @(posedge sys_clk);
    `CHK(last_len, CONV_CYC << 1)
    rchk(IDX_IRR, 32'h00000020);
    `CHK({irq, wakes - w}, {1'b0, 32'd0})
    wreg(IDX_IRR, 32'h00000000);
    wreg(IDX_IEN, 32'h00000020);
  endtask

  task automatic t_standby_continuous();
    int r0;
    wreg(IDX_STBY, 32'h00000000);
    wreg(IDX_SSR, 32'h000000A0);
    wait_bit(IDX_SSR, SSR_BUSY, 1'b0, 1);
    `CHK(modulator_run, 1'b0)
    wreg(IDX_STBY, 32'h00000008);
    r0 = rises;
    // Continuous mode with code 100, which runs at the full rate
    wreg(IDX_CTRL, 32'h000000C4);
    repeat (700) @(posedge sys_clk);
    `CHK(rises - r0 >= 2, 1'b1)
    wreg(IDX_CTRL, 32'h00000004);
    wait_bit(IDX_SSR, SSR_BUSY, 1'b0, 300);
    repeat (2) @(posedge sys_clk);
    `CHK(last_len, CONV_CYC)
  endtask

  task automatic t_measure();
    logic [13:0] s0;
    wreg(IDX_SSR, 32'h00000018);
    for (int slot = 0; slot < 2; slot++)
    begin
      s0 = i_model.cnt_q;
      wreg(IDX_MEAS, (slot << SLOT_LSB) | 1);
      wait_bit(IDX_MEAS, MEAS_DONE, 1'b1, 8000);
      `CHK(i_model.cnt_q - s0, 14'd65)
      rchk(IDX_AVG + 16'(slot), {18'h0, 14'h1000 + s0 + 14'd33});
    end
  endtask

  // --------------------------------------------------------------
  // Run control
  // --------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard sized well beyond two full measurements
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset_and_map();
    t_control_fields();
    t_single_and_irq();
    t_standby_continuous();
    t_measure();
    end_sim();
  end
endmodule
